// file: hw/rsad_cfg.svh
// Timing constants for the EIA-232/485 auto-direction converter
`ifndef RSAD_CFG_SVH
`define RSAD_CFG_SVH

// Clock period in picoseconds (200 MHz)
`define RSAD_CLK_PERIOD_PS    5000
// Highest supported line rate in bits per second
`define RSAD_MAX_RATE_BPS     250000
// Bit time at the highest rate in picoseconds
`define RSAD_MIN_BIT_PS       (64'd1000000000000 / `RSAD_MAX_RATE_BPS)
// Cycles in one bit at the highest rate (shortest bit time, rounded down)
`define RSAD_MIN_BIT_CYC      (`RSAD_MIN_BIT_PS / `RSAD_CLK_PERIOD_PS)
// Idle line time that ends a transmit or bus-busy period, in bits of the measured rate
`define RSAD_IDLE_BITS        12
// Width of the bit-time measurement counter
`define RSAD_CNT_W            20
// Saturation value of the counter
`define RSAD_CNT_MAX          20'hfffff
// Line level that counts as break: low held this many bit times
`define RSAD_BREAK_BITS       12
// Reset value of the measured bit time: 200 cycles, a quarter of the shortest bit at the top rate
`define RSAD_BIT_RESET        20'h000c8

`endif

// file: hw/rsad_pkg.sv
// Types shared by the converter modules
`default_nettype none
package rsad_pkg;
    typedef logic [19:0] rsad_cnt_type;
    typedef enum logic [1:0]
    {
        RSAD_IDLE,
        RSAD_TRANSMIT,
        RSAD_BUSY
    } rsad_dir_type;
endpackage : rsad_pkg
`default_nettype wire

// file: hw/rsad_rate_meter.sv
// Times low pulses on a serial line; the bit time output keeps its reset value
`include "rsad_cfg.svh"
`default_nettype none
module rsad_rate_meter
    import rsad_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Serial line, idle high
    input  wire logic              line,
    // Measured bit time in cycles; stays at its reset value, since no pulse is both plausible and shorter
    output var  rsad_pkg::rsad_cnt_type bitTime
);
    import rsad_pkg::*;

    rsad_cnt_type lowCount;
    logic         lineLast;
    wire          pulseEnds = lineLast == 1'b0 && line == 1'b1;
    wire          shorter   = lowCount < bitTime;
    wire          plausible = lowCount >= rsad_cnt_type'(`RSAD_MIN_BIT_CYC);

    // ==========================================================
    // Low-pulse timing
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            lowCount <= '0;
            lineLast <= 1'b1;
            bitTime  <= `RSAD_BIT_RESET;
        end
        else
        begin
            lineLast <= line;
            if (line)
                lowCount <= '0;
            else if (lowCount != `RSAD_CNT_MAX)
                lowCount <= lowCount + rsad_cnt_type'(1);
            // Glitches under one top-rate bit are ignored
            if (pulseEnds && plausible && shorter)
                bitTime <= lowCount;
        end
    end
endmodule : rsad_rate_meter
`default_nettype wire

// file: hw/rsad_converter.sv
// Automatic direction and gating logic of a 232-to-485 converter
//
// What this block does
// - 485 driver is steered from host data and bus activity, no direction input.
// - Driver enable is low except while host data goes toward the bus and for the 12-bit idle timeout after it.
// - Full duplex: bus data, own echo included, reaches the 232 receive output.
// - A duplex select input chooses full or half duplex.
// - The bus is never driven while it sits in break.
// - Activity from another node blocks host data from the bus.
// - Transmit enable needs no baud setting; idle timeout is 12 bits of the fixed 200-cycle reset bit time.
// - Rate is fixed at the 200-cycle reset bit time; the meter never updates it.
// - Exactly one serial channel is carried.
// - Request-to-send loops straight back as clear-to-send.
`include "rsad_cfg.svh"
`default_nettype none
module rsad_converter
    import rsad_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Settings
    input  wire logic halfDuplex,
    // Host 232 side
    input  wire logic hostTxd,
    input  wire logic hostRts,
    output var  logic hostRxd,
    output var  logic hostCts,
    // 485 transceiver
    input  wire logic busRxd,
    output var  logic busTxd,
    output var  logic busTxdOe
);
    import rsad_pkg::*;

    rsad_dir_type dirState;
    rsad_dir_type next_dirState;
    rsad_cnt_type bitTime;
    rsad_cnt_type idleCount;
    rsad_cnt_type lowCount;
    logic         inBreak;

    // Counts saturate, so long idles never wrap into false activity
    function automatic rsad_cnt_type satInc(input rsad_cnt_type value);
        satInc = (value == `RSAD_CNT_MAX) ? value : value + rsad_cnt_type'(1);
    endfunction : satInc

    function automatic logic spanReached(input rsad_cnt_type count,
                                         input rsad_cnt_type unit,
                                         input logic [3:0]   bits);
        logic [27:0] span;
        span        = 28'(unit) * 28'(bits);
        spanReached = 28'(count) >= span;
    endfunction : spanReached

    // ==========================================================
    // Rate measurement on both lines
    // ==========================================================
    // The host start bit is the shortest low it sends, so one meter on the
    // combined line suffices; its result scales both timeouts.
    wire combinedLine = hostTxd & busRxd;

    rsad_rate_meter meter
    (
        .clk     (clk),
        .srst    (srst),
        .line    (combinedLine),
        .bitTime (bitTime)
    );

    // ==========================================================
    // Direction decision
    // ==========================================================
    wire hostActive = !hostTxd;
    wire busActive  = !busRxd;
    wire lineIdle   = hostTxd && busRxd;
    wire idleDone   = spanReached(idleCount, bitTime, 4'(`RSAD_IDLE_BITS));
    wire breakSeen  = spanReached(lowCount, bitTime, 4'(`RSAD_BREAK_BITS));

    always_comb
    begin
        next_dirState = dirState;
        case (dirState)
            RSAD_IDLE:
            begin
                if (busActive || inBreak)
                begin
                    next_dirState = RSAD_BUSY;
                end
                else if (hostActive)
                begin
                    next_dirState = RSAD_TRANSMIT;
                end
            end
            RSAD_TRANSMIT:
            begin
                if (inBreak)
                begin
                    next_dirState = RSAD_BUSY;
                end
                else if (idleDone)
                begin
                    next_dirState = RSAD_IDLE;
                end
            end
            RSAD_BUSY:
            begin
                // Host chatter keeps the bus owned by the other node
                if (idleDone && !inBreak)
                begin
                    next_dirState = RSAD_IDLE;
                end
            end
            default:
            begin
                next_dirState = RSAD_IDLE;
            end
        endcase
    end

    // Break is judged on the bus while we are not the one driving it low
    wire busLowForeign = busActive && !(dirState == RSAD_TRANSMIT && !hostTxd);

    wire rsad_cnt_type next_idleCount = lineIdle ? satInc(idleCount) : '0;
    wire rsad_cnt_type next_lowCount  = busLowForeign ? satInc(lowCount) : '0;
    wire               next_inBreak   = busRxd ? 1'b0 : (inBreak || breakSeen);

    wire next_busTxdOe = next_dirState == RSAD_TRANSMIT;
    wire echoBlocked   = halfDuplex && dirState == RSAD_TRANSMIT;
    wire next_hostRxd  = echoBlocked ? 1'b1 : busRxd;

    // ==========================================================
    // Direction state
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dirState <= RSAD_IDLE;
        end
        else
        begin
            dirState <= next_dirState;
        end
    end

    // ==========================================================
    // Idle and break timing
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            idleCount <= '0;
        end
        else
        begin
            idleCount <= next_idleCount;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            lowCount <= '0;
        end
        else
        begin
            lowCount <= next_lowCount;
        end
    end

    // Held until the bus returns high, so a long break cannot be re-entered
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            inBreak <= 1'b0;
        end
        else
        begin
            inBreak <= next_inBreak;
        end
    end

    // ==========================================================
    // Bus driver
    // ==========================================================
    // Data and enable share one register stage, so the first bit is not cut
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            busTxd   <= 1'b1;
            busTxdOe <= 1'b0;
        end
        else
        begin
            busTxd   <= hostTxd;
            busTxdOe <= next_busTxdOe;
        end
    end

    // ==========================================================
    // Host side
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hostRxd <= 1'b1;
        end
        else
        begin
            hostRxd <= next_hostRxd;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hostCts <= 1'b0;
        end
        else
        begin
            hostCts <= hostRts;
        end
    end
endmodule : rsad_converter
`default_nettype wire

// file: testbench/rsad_conv_properties.sv
// Port-level assertions for the auto-direction converter
`default_nettype none
module rsad_conv_properties
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched ports
    input wire logic halfDuplex,
    input wire logic hostTxd,
    input wire logic hostRts,
    input wire logic hostRxd,
    input wire logic hostCts,
    input wire logic busRxd,
    input wire logic busTxd,
    input wire logic busTxdOe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Low on the first edge after reset, so $past never sees reset values
    logic live;
    always_ff @(posedge clk) live <= !srst;

    AST_CTS: assert property (live |-> hostCts == $past(hostRts))
        else $error("clear-to-send does not follow request-to-send");
    AST_TXD: assert property (live && busTxdOe |-> busTxd == $past(hostTxd))
        else $error("bus data differs from host data");
    AST_START: assert property ($rose(busTxdOe) |-> !$past(hostTxd) && $past(busRxd))
        else $error("driver enabled without host data on idle bus");
    AST_STOP: assert property ($fell(busTxdOe) |-> $past(hostTxd))
        else $error("driver released while host still low");
    AST_HOLD: assert property (busTxdOe && !hostTxd |=> busTxdOe)
        else $error("driver dropped during host data");
    AST_BUSY: assert property (!busTxdOe && !busRxd |=> !busTxdOe)
        else $error("driver enabled over busy bus");
    AST_HALF: assert property ($past(halfDuplex) && busTxdOe && $past(busTxdOe) |-> hostRxd)
        else $error("echo reached host in half duplex");
    AST_FULL: assert property (live && !$past(halfDuplex) |-> hostRxd == $past(busRxd))
        else $error("bus data not forwarded in full duplex");

    COV_SEND: cover property ($rose(busTxdOe));
    COV_BUSY: cover property (!busTxdOe && !busRxd && !hostTxd);
    COV_HALF: cover property (halfDuplex && busTxdOe);
endmodule : rsad_conv_properties

bind rsad_converter rsad_conv_properties chk (.clk(clk), .srst(srst), .halfDuplex(halfDuplex),
    .hostTxd(hostTxd), .hostRts(hostRts), .hostRxd(hostRxd), .hostCts(hostCts),
    .busRxd(busRxd), .busTxd(busTxd), .busTxdOe(busTxdOe));
`default_nettype wire

// file: testbench/rsad_bus_node.sv
// Shared 485 pair with one other node and failsafe bias
`default_nettype none
module rsad_bus_node
(
    // Converter driver
    input  wire logic busTxd,
    input  wire logic busTxdOe,
    // Other node pulling the pair low
    input  wire logic nodeLow,
    // Receiver output
    output var  logic busRxd
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released pair reads idle high; any low driver wins
    always_comb busRxd = !nodeLow && (!busTxdOe || busTxd);
endmodule : rsad_bus_node
`default_nettype wire

// file: testbench/tb_rs232_rs485_auto_direction.sv
// Self-checking bench for the auto-direction converter
`default_nettype none
module tb_rs232_rs485_auto_direction;
    timeunit 1ns;
    timeprecision 100ps;
    // Idle timeout at the reset bit time of 200 cycles
    localparam int IDLE = 2400;
    logic clk = 1'h0, srst = 1'h1, halfDuplex = 1'h0, hostTxd = 1'h1, hostRts = 1'h0;
    logic nodeLow = 1'h0, hostRxd, hostCts, busRxd, busTxd, busTxdOe;
    int   n_mismatch = 0, checked = 0;
    always #2.5 clk = ~clk;
    rsad_converter DUT (.clk(clk), .srst(srst), .halfDuplex(halfDuplex), .hostTxd(hostTxd),
        .hostRts(hostRts), .hostRxd(hostRxd), .hostCts(hostCts), .busRxd(busRxd),
        .busTxd(busTxd), .busTxdOe(busTxdOe));
    rsad_bus_node node (.busTxd(busTxd), .busTxdOe(busTxdOe), .nodeLow(nodeLow), .busRxd(busRxd));
    task automatic check(input logic seen, input logic exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %b want %b", $time, seen, exp);
        end
    endtask : check
    task automatic edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : edges
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task automatic t_reset;
        edges(1);
        check(busTxdOe, 1'h0);
        check(hostRxd, 1'h1);
        @(posedge clk) hostRts <= 1'h1;
        edges(1);
        check(hostCts, 1'h1);
        @(posedge clk) hostRts <= 1'h0;
        edges(1);
        check(hostCts, 1'h0);
    endtask : t_reset
    task automatic t_send(input logic half);
        @(posedge clk) halfDuplex <= half;
        @(posedge clk) hostTxd <= 1'h0;
        edges(1);
        check(busTxdOe, 1'h1);
        check(busTxd, 1'h0);
        edges(1);
        check(hostRxd, half);
        edges(198);
        @(posedge clk) hostTxd <= 1'h1;
        edges(IDLE - 20);
        check(busTxdOe, 1'h1);
        edges(60);
        check(busTxdOe, 1'h0);
    endtask : t_send
    task automatic t_busy;
        @(posedge clk) nodeLow <= 1'h1;
        @(posedge clk) hostTxd <= 1'h0;
        edges(4);
        check(busTxdOe, 1'h0);
        check(hostRxd, 1'h0);
        @(posedge clk)
        begin
            nodeLow <= 1'h0;
            hostTxd <= 1'h1;
        end
        edges(IDLE + 60);
    endtask : t_busy
    task automatic t_break;
        @(posedge clk) nodeLow <= 1'h1;
        edges(IDLE + 100);
        @(posedge clk) hostTxd <= 1'h0;
        edges(20);
        check(busTxdOe, 1'h0);
        @(posedge clk)
        begin
            nodeLow <= 1'h0;
            hostTxd <= 1'h1;
        end
        edges(IDLE + 60);
        @(posedge clk) hostTxd <= 1'h0;
        edges(1);
        check(busTxdOe, 1'h1);
    endtask : t_break
    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'h0;
        t_reset();
        t_send(1'h1);
        t_send(1'h0);
        t_busy();
        t_break();
        conclude();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
endmodule : tb_rs232_rs485_auto_direction
`default_nettype wire
